// *** include/flash_host_defines.svh ***
// register map, command codes and timing counts, flash host
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH
// ========================================
// register offsets and fields
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_ADDR 8'h08
`define REG_DATA 8'h0c
`define REG_STAT 8'h10
`define REG_PULSE 8'h14
`define REG_WHERE 8'h18
`define CTRL_VPP_BIT 0
`define ADDR_RST 17'h00000
`define BYTE_RST 8'h00
// ========================================
// command codes and fixed bytes
`define CODE_READ 8'h00
`define CODE_IDENT 8'h90
`define CODE_ERASE 8'h20
`define CODE_ERASE_CHECK 8'ha0
`define CODE_PROGRAM 8'h40
`define CODE_PROGRAM_CHECK 8'hc0
`define CODE_RESET 8'hff
`define ERASED_BYTE 8'hff
`define ZERO_BYTE 8'h00
`define ID_MAKER_ADDR 17'h00000
`define ID_PART_ADDR 17'h00001
`define LAST_ADDR 17'h1ffff
`define ERASE_MAX 10'd1000
`define PROG_MAX 5'd25
// ========================================
// timing, 40 MHz clock
`define CLK_NS 25
`define T_RECOVER_NS 6000
`define T_PROG_NS 10000
`define T_ERASE_MS 10
`define T_ACC_NS 200
`define RECOVER_CYC ((`T_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_CYC ((`T_PROG_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASE_CYC ((`T_ERASE_MS * 1000000 + `CLK_NS - 1) / `CLK_NS)
`define READ_WAIT_CYC ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS + 2)
`define WE_LOW_CYC 4'h3
`endif

// *** include/flash_host_pkg.sv ***
// types shared by the flash erase host modules
package flash_host_pkg;
  typedef logic [7:0]  reg_addr_t;
  typedef logic [16:0] flash_addr_t;
  typedef logic [7:0]  byte_t;
  typedef logic [18:0] tick_t;
  // software order codes, in this fixed order
  typedef enum logic [2:0] {OP_NONE, OP_READ, OP_PROGRAM, OP_ERASE,
                            OP_IDENT, OP_RESET, OP_ABORT} op_t;
  typedef enum logic [4:0] {ST_IDLE, ST_RD_CMD, ST_RD_REC, ST_RD_GET,
                            ST_PG_SETUP, ST_PG_DATA, ST_PG_PULSE, ST_PG_VFY,
                            ST_PG_REC, ST_PG_GET, ST_ER_SETUP, ST_ER_GO,
                            ST_ER_PULSE, ST_ER_VFY, ST_ER_REC, ST_ER_GET,
                            ST_ID_CMD, ST_ID_GET0, ST_ID_GET1, ST_RST_A,
                            ST_RST_B, ST_FINISH} host_state_t;
  typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD,
                            CY_READ, CY_DONE} cyc_state_t;
endpackage

// *** include/host_link_if.sv ***
// links the sequencer to its pin cycle engine and its wait timer
interface host_link_if;
  logic                        cyc_req;   // cycle wanted
  logic                        cyc_write; // write, else read
  flash_host_pkg::flash_addr_t cyc_addr;  // pin address
  flash_host_pkg::byte_t       cyc_wdata; // write byte
  logic                        cyc_done;  // one-cycle end pulse
  flash_host_pkg::byte_t       cyc_rdata; // byte read
  logic                        tmr_load;  // start a wait
  flash_host_pkg::tick_t       tmr_value; // wait length in cycles
  logic                        tmr_expired;
  modport seq (output cyc_req, cyc_write, cyc_addr, cyc_wdata, tmr_load, tmr_value,
               input cyc_done, cyc_rdata, tmr_expired);
  modport cyc (input cyc_req, cyc_write, cyc_addr, cyc_wdata,
               output cyc_done, cyc_rdata);
  modport tmr (input tmr_load, tmr_value, output tmr_expired);
endinterface

// *** logic/flash_wait_timer.sv ***
// down counter that times recovery and pulse waits
`include "flash_host_defines.svh"
module flash_wait_timer (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // sequencer side
  host_link_if.tmr link
);
  import flash_host_pkg::*;
  tick_t cnt_q; // cycles left
  tick_t cnt_d;
  // ========================================
  // count down, reload wins over counting
  always_comb begin
    cnt_d = cnt_q;
    if (link.tmr_load) begin
      cnt_d = link.tmr_value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 19'h00001;
    end
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign link.tmr_expired = (cnt_q == '0);
endmodule // flash_wait_timer

// *** logic/flash_pin_cycle.sv ***
// one write or read cycle on the flash pins
`include "flash_host_defines.svh"
module flash_pin_cycle (
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  // sequencer side
  host_link_if.cyc                    link,
  // flash pins
  output logic                        o_chip_enable_n,
  output logic                        o_output_enable_n,
  output logic                        o_write_enable_n,
  output flash_host_pkg::flash_addr_t o_addr,
  input  wire flash_host_pkg::byte_t  i_data_lines,
  output flash_host_pkg::byte_t       o_data_lines,
  output logic                        o_data_lines_oe
);
  import flash_host_pkg::*;
  cyc_state_t  st_q, st_d;
  logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic        doe_q, doe_d, wr_q, wr_d;
  flash_addr_t addr_q, addr_d;
  byte_t       dout_q, dout_d, rdata_q, rdata_d;
  logic [3:0]  cnt_q, cnt_d; // strobe or access wait
  byte_t       meta_q, sync_q; // data pin synchroniser
  // ========================================
  // cycle sequencing
  always_comb begin
    st_d = st_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    doe_d = doe_q;
    wr_d = wr_q;
    addr_d = addr_q;
    dout_d = dout_q;
    rdata_d = rdata_q;
    cnt_d = cnt_q;
    unique case (st_q)
      CY_IDLE: if (link.cyc_req) begin
        st_d = CY_SETUP;
        ce_n_d = 1'b0;
        addr_d = link.cyc_addr;
        dout_d = link.cyc_wdata;
        doe_d = link.cyc_write;
        oe_n_d = link.cyc_write; // output enable stays high on writes [RL3]
        wr_d = link.cyc_write;
        cnt_d = link.cyc_write ? `WE_LOW_CYC : 4'(`READ_WAIT_CYC);
      end
      // address settles a cycle before write enable falls [RL8]
      CY_SETUP: begin
        st_d = wr_q ? CY_STROBE : CY_READ;
        we_n_d = !wr_q;
      end
      CY_STROBE: if (cnt_q == 4'h1) begin
        we_n_d = 1'b1; // data still driven across this rising edge [RL9]
        st_d = CY_HOLD;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      CY_HOLD: begin
        st_d = CY_DONE;
        ce_n_d = 1'b1;
        doe_d = 1'b0;
      end
      CY_READ: if (cnt_q == 4'h1) begin
        rdata_d = sync_q;
        oe_n_d = 1'b1;
        ce_n_d = 1'b1;
        st_d = CY_DONE;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      CY_DONE: st_d = CY_IDLE;
      default: st_d = CY_IDLE;
    endcase
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= CY_IDLE;
      {ce_n_q, oe_n_q, we_n_q} <= 3'h7;
      {doe_q, wr_q} <= 2'h0;
      addr_q <= `ADDR_RST;
      dout_q <= `BYTE_RST;
      rdata_q <= `BYTE_RST;
      cnt_q <= 4'h0;
      meta_q <= `BYTE_RST;
      sync_q <= `BYTE_RST;
    end else begin
      st_q <= st_d;
      {ce_n_q, oe_n_q, we_n_q} <= {ce_n_d, oe_n_d, we_n_d};
      {doe_q, wr_q} <= {doe_d, wr_d};
      addr_q <= addr_d;
      dout_q <= dout_d;
      rdata_q <= rdata_d;
      cnt_q <= cnt_d;
      meta_q <= i_data_lines; // pins are asynchronous to our clock
      sync_q <= meta_q;
    end
  end
  assign link.cyc_done = (st_q == CY_DONE);
  assign link.cyc_rdata = rdata_q;
  assign o_chip_enable_n = ce_n_q;
  assign o_output_enable_n = oe_n_q;
  assign o_write_enable_n = we_n_q;
  assign o_addr = addr_q;
  assign o_data_lines = dout_q;
  assign o_data_lines_oe = doe_q;
endmodule // flash_pin_cycle

// *** logic/flash_erase_host.sv ***
// flash host: read, program, erase and id sequences
//
// Local design decisions: the address map and the strobed register port.
`include "flash_host_defines.svh"
// Function
// RL1 - commands use top three bits, few exceptions
// RL2 - id codes read at offsets zero, one
// RL3 - writes need output enable high, others low
// RL4 - without high voltage, read-only memory
// RL5 - command latch works only with high voltage
// RL6 - read code selects and keeps read mode
// RL7 - wait after read command
// RL8 - address taken at write enable fall
// RL9 - program data taken at write enable rise
// RL10 - program check reuses program address
// RL11 - first erase code only arms
// RL12 - second erase code starts bulk erase
// RL13 - only erase check code ends erase
// RL14 - erase check ends erase, takes address
// RL15 - all ones read means byte erased
// RL16 - fresh erase check per next byte
// RL17 - on failure erase again, resume there
// RL18 - end checking with another valid command
// RL19 - host times each erase pulse
// RL20 - stop erase before servicing interruptions
// RL21 - program whole array to zero first
// RL22 - check from zero up, pulse budget
// RL23 - program code arms, next write programs
// RL24 - recover before check read
// RL25 - high voltage is one digital level
// RL26 - reset code twice returns read mode
module flash_erase_host #(
  parameter int unsigned          ERASE_PULSE_CYC = `ERASE_CYC,
  parameter flash_host_pkg::flash_addr_t LAST_ADDR = `LAST_ADDR
) (
  // clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_reset_n,
  // software register port
  input  wire flash_host_pkg::reg_addr_t i_reg_addr,
  input  wire logic [31:0]               i_reg_wdata,
  input  wire logic                      i_reg_write,
  input  wire logic                      i_reg_read,
  output logic [31:0]                    o_reg_rdata,
  // flash pins
  output logic                           o_chip_enable_n,
  output logic                           o_output_enable_n,
  output logic                           o_write_enable_n,
  output flash_host_pkg::flash_addr_t    o_addr,
  input  wire flash_host_pkg::byte_t     i_data_lines,
  output flash_host_pkg::byte_t          o_data_lines,
  output logic                           o_data_lines_oe,
  output logic                           o_vpp_high
);
  import flash_host_pkg::*;
  // ========================================
  // sub-blocks
  host_link_if link ();
  flash_pin_cycle u_pins (
    .i_clock           (i_clock),
    .i_reset_n         (i_reset_n),
    .link              (link),
    .o_chip_enable_n   (o_chip_enable_n),
    .o_output_enable_n (o_output_enable_n),
    .o_write_enable_n  (o_write_enable_n),
    .o_addr            (o_addr),
    .i_data_lines      (i_data_lines),
    .o_data_lines      (o_data_lines),
    .o_data_lines_oe   (o_data_lines_oe)
  );
  flash_wait_timer u_timer (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .link      (link)
  );
  // ========================================
  // state
  host_state_t state_q, state_d; // sequence step
  logic        vpp_q, vpp_d; // high voltage request
  logic        erase_q, erase_d; // preprogram belongs to an erase
  logic        abort_q, abort_d; // software wants the erase stopped
  logic        pend_q, pend_d; // failure to report at the end
  logic        done_q, done_d; // sticky finished flag
  logic        fail_q, fail_d; // sticky failure flag
  flash_addr_t addr_q, addr_d; // software target address
  flash_addr_t cur_q, cur_d; // address being worked on
  byte_t       data_q, data_d; // software program byte
  byte_t       pbyte_q, pbyte_d; // byte being programmed
  byte_t       rbyte_q, rbyte_d; // last byte read from the part
  byte_t       maker_q, maker_d; // id byte at offset zero
  byte_t       part_q, part_d; // id byte at offset one
  logic [4:0]  pcnt_q, pcnt_d; // failed program pulses
  logic [9:0]  ecnt_q, ecnt_d; // erase pulses given
  logic [31:0] rdata_q, rdata_d; // register read answer
  logic        cmd_wr; // order register written
  op_t         op; // order being written
  logic        bus_req, bus_wr; // pin cycle request
  flash_addr_t bus_addr;
  byte_t       bus_wdata;
  logic        busy;
  assign cmd_wr = i_reg_write && (i_reg_addr == `REG_CMD);
  assign op = op_t'(i_reg_wdata[2:0]);
  assign busy = (state_q != ST_IDLE);
  assign o_vpp_high = vpp_q; // single level, high voltage wanted [RL25]
  // ========================================
  // pin cycle each step asks for
  always_comb begin
    bus_req = 1'b1;
    bus_wr = 1'b1;
    bus_addr = cur_q;
    bus_wdata = `CODE_READ;
    unique case (state_q)
      ST_IDLE, ST_RD_REC, ST_PG_PULSE, ST_PG_REC, ST_ER_PULSE, ST_ER_REC: bus_req = 1'b0;
      ST_RD_CMD, ST_FINISH: bus_wdata = `CODE_READ; // back to read mode [RL6] [RL18]
      ST_RD_GET, ST_PG_GET, ST_ER_GET: bus_wr = 1'b0;
      ST_ID_GET0: begin
        bus_wr = 1'b0;
        bus_addr = `ID_MAKER_ADDR; // [RL2]
      end
      ST_ID_GET1: begin
        bus_wr = 1'b0;
        bus_addr = `ID_PART_ADDR; // [RL2]
      end
      ST_PG_SETUP: bus_wdata = `CODE_PROGRAM; // arming write [RL23]
      ST_PG_DATA: bus_wdata = pbyte_q; // address and byte together [RL23] [RL9]
      ST_PG_VFY: bus_wdata = `CODE_PROGRAM_CHECK; // part reuses its address [RL10]
      ST_ER_SETUP, ST_ER_GO: bus_wdata = `CODE_ERASE; // arm, then start [RL11] [RL12]
      ST_ER_VFY: bus_wdata = `CODE_ERASE_CHECK; // carries checked address [RL14]
      ST_ID_CMD: bus_wdata = `CODE_IDENT; // [RL1] [RL2]
      ST_RST_A, ST_RST_B: bus_wdata = `CODE_RESET; // two reset writes [RL26]
    endcase
  end
  assign link.cyc_req = bus_req;
  assign link.cyc_write = bus_wr;
  assign link.cyc_addr = bus_addr;
  assign link.cyc_wdata = bus_wdata;
  // ========================================
  // sequencer and software registers, next values
  always_comb begin
    state_d = state_q;
    vpp_d = vpp_q;
    erase_d = erase_q;
    abort_d = abort_q;
    pend_d = pend_q;
    done_d = done_q;
    fail_d = fail_q;
    addr_d = addr_q;
    cur_d = cur_q;
    data_d = data_q;
    pbyte_d = pbyte_q;
    rbyte_d = rbyte_q;
    maker_d = maker_q;
    part_d = part_q;
    pcnt_d = pcnt_q;
    ecnt_d = ecnt_q;
    link.tmr_load = 1'b0;
    link.tmr_value = tick_t'(`RECOVER_CYC);
    // plain register writes
    if (i_reg_write && i_reg_addr == `REG_CTRL && !busy) begin
      vpp_d = i_reg_wdata[`CTRL_VPP_BIT]; // voltage never drops mid-sequence
    end
    if (i_reg_write && i_reg_addr == `REG_ADDR) begin
      addr_d = i_reg_wdata[16:0];
    end
    if (i_reg_write && i_reg_addr == `REG_DATA) begin
      data_d = i_reg_wdata[7:0];
    end
    if (cmd_wr && busy && op == OP_ABORT) begin
      abort_d = 1'b1;
    end
    unique case (state_q)
      ST_IDLE: begin
        abort_d = 1'b0;
        if (cmd_wr && op != OP_NONE && op != OP_ABORT) begin
          done_d = 1'b0;
          fail_d = 1'b0;
          pend_d = 1'b0;
          erase_d = 1'b0;
          pcnt_d = 5'h00;
          ecnt_d = 10'h000;
          cur_d = addr_q;
          pbyte_d = data_q;
          if (op == OP_READ) begin
            // without high voltage the part is read-only, no command [RL4]
            state_d = vpp_q ? ST_RD_CMD : ST_RD_GET;
          end else if (!vpp_q) begin
            // the latch ignores commands without high voltage [RL5]
            done_d = 1'b1;
            fail_d = 1'b1;
          end else begin
            unique case (op)
              OP_PROGRAM: state_d = ST_PG_SETUP;
              OP_ERASE: begin
                erase_d = 1'b1;
                cur_d = `ADDR_RST;
                pbyte_d = `ZERO_BYTE; // whole array to zero first [RL21]
                state_d = ST_PG_SETUP;
              end
              OP_IDENT: state_d = ST_ID_CMD;
              OP_RESET: state_d = ST_RST_A;
              default: state_d = ST_IDLE;
            endcase
          end
        end
      end
      ST_RD_CMD: if (link.cyc_done) begin
        link.tmr_load = 1'b1; // settle after the read code [RL7]
        state_d = ST_RD_REC;
      end
      ST_RD_REC: if (link.tmr_expired) begin
        state_d = ST_RD_GET; // [RL7]
      end
      ST_RD_GET: if (link.cyc_done) begin
        rbyte_d = link.cyc_rdata;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_PG_SETUP: if (link.cyc_done) begin
        state_d = ST_PG_DATA;
      end
      ST_PG_DATA: if (link.cyc_done) begin
        link.tmr_load = 1'b1;
        link.tmr_value = tick_t'(`PROG_CYC);
        state_d = ST_PG_PULSE;
      end
      ST_PG_PULSE: if (link.tmr_expired) begin
        state_d = ST_PG_VFY;
      end
      ST_PG_VFY: if (link.cyc_done) begin
        link.tmr_load = 1'b1; // recovery before the check read [RL24]
        state_d = ST_PG_REC;
      end
      ST_PG_REC: if (link.tmr_expired) begin
        state_d = ST_PG_GET;
      end
      ST_PG_GET: if (link.cyc_done) begin
        rbyte_d = link.cyc_rdata;
        if (link.cyc_rdata == pbyte_q) begin
          pcnt_d = 5'h00;
          if (!erase_q) begin
            state_d = ST_FINISH;
          end else if (cur_q == LAST_ADDR) begin
            cur_d = `ADDR_RST; // checking starts at the lowest address [RL22]
            state_d = ST_ER_SETUP;
          end else begin
            cur_d = cur_q + 17'h00001;
            state_d = ST_PG_SETUP;
          end
        end else if (pcnt_q == `PROG_MAX - 5'h01) begin
          pend_d = 1'b1;
          state_d = ST_FINISH;
        end else begin
          pcnt_d = pcnt_q + 5'h01;
          state_d = ST_PG_SETUP;
        end
      end
      ST_ER_SETUP: if (link.cyc_done) begin
        state_d = ST_ER_GO; // arming alone leaves the array alone [RL11]
      end
      ST_ER_GO: if (link.cyc_done) begin
        ecnt_d = ecnt_q + 10'h001;
        link.tmr_load = 1'b1; // erase pulse timed here [RL19]
        link.tmr_value = tick_t'(ERASE_PULSE_CYC);
        state_d = ST_ER_PULSE;
      end
      ST_ER_PULSE: if (link.tmr_expired || abort_q) begin
        // an abort still goes through the erase check write [RL20] [RL13]
        state_d = ST_ER_VFY;
      end
      ST_ER_VFY: if (link.cyc_done) begin
        if (abort_q) begin
          pend_d = 1'b1;
          state_d = ST_FINISH;
        end else begin
          link.tmr_load = 1'b1; // [RL24]
          state_d = ST_ER_REC;
        end
      end
      ST_ER_REC: if (link.tmr_expired) begin
        state_d = ST_ER_GET;
      end
      ST_ER_GET: if (link.cyc_done) begin
        rbyte_d = link.cyc_rdata;
        if (link.cyc_rdata == `ERASED_BYTE) begin // [RL15]
          if (cur_q == LAST_ADDR) begin
            state_d = ST_FINISH; // read code closes the checking [RL18]
          end else begin
            cur_d = cur_q + 17'h00001;
            state_d = ST_ER_VFY; // fresh check write per byte [RL16]
          end
        end else if (ecnt_q == `ERASE_MAX) begin
          pend_d = 1'b1; // pulse budget spent [RL22]
          state_d = ST_FINISH;
        end else begin
          state_d = ST_ER_SETUP; // erase again, keep failing address [RL17]
        end
      end
      ST_ID_CMD: if (link.cyc_done) begin
        state_d = ST_ID_GET0;
      end
      ST_ID_GET0: if (link.cyc_done) begin
        maker_d = link.cyc_rdata;
        state_d = ST_ID_GET1;
      end
      ST_ID_GET1: if (link.cyc_done) begin
        part_d = link.cyc_rdata;
        state_d = ST_FINISH;
      end
      ST_RST_A: if (link.cyc_done) begin
        state_d = ST_RST_B;
      end
      ST_RST_B: if (link.cyc_done) begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_FINISH: if (link.cyc_done) begin
        done_d = 1'b1;
        fail_d = pend_q;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end
  // ========================================
  // register read answer, valid one cycle after the strobe only
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_reg_read) begin
      unique case (i_reg_addr)
        `REG_CTRL: rdata_d = {31'h0000_0000, vpp_q};
        `REG_ADDR: rdata_d = {15'h0000, addr_q};
        `REG_DATA: rdata_d = {16'h0000, data_q, rbyte_q};
        `REG_STAT: rdata_d = {8'h00, part_q, maker_q, 5'h00, fail_q, done_q, busy};
        `REG_PULSE: rdata_d = {17'h0_0000, pcnt_q, ecnt_q};
        `REG_WHERE: rdata_d = {15'h0000, cur_q};
        default: rdata_d = 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end
  // ========================================
  // registers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      {vpp_q, erase_q, abort_q, pend_q, done_q, fail_q} <= 6'h00;
      addr_q <= `ADDR_RST;
      cur_q <= `ADDR_RST;
      data_q <= `BYTE_RST;
      pbyte_q <= `BYTE_RST;
      rbyte_q <= `BYTE_RST;
      maker_q <= `BYTE_RST;
      part_q <= `BYTE_RST;
      pcnt_q <= 5'h00;
      ecnt_q <= 10'h000;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      {vpp_q, erase_q, abort_q, pend_q, done_q, fail_q} <=
        {vpp_d, erase_d, abort_d, pend_d, done_d, fail_d};
      addr_q <= addr_d;
      cur_q <= cur_d;
      data_q <= data_d;
      pbyte_q <= pbyte_d;
      rbyte_q <= rbyte_d;
      maker_q <= maker_d;
      part_q <= part_d;
      pcnt_q <= pcnt_d;
      ecnt_q <= ecnt_d;
      rdata_q <= rdata_d;
    end
  end
  assign o_reg_rdata = rdata_q;
endmodule // flash_erase_host

// *** tb/flash_erase_host_props.sv ***
// pin-level assertions for the flash erase host
module flash_erase_host_props #(
  parameter int unsigned                 ERASE_PULSE_CYC = 50,
  parameter flash_host_pkg::flash_addr_t LAST_ADDR       = 17'h00007
) (
  // clock and reset
  input wire logic                        i_clock,
  input wire logic                        i_reset_n,
  // flash pins
  input wire logic                        o_chip_enable_n,
  input wire logic                        o_output_enable_n,
  input wire logic                        o_write_enable_n,
  input wire flash_host_pkg::flash_addr_t o_addr,
  input wire flash_host_pkg::byte_t       o_data_lines,
  input wire logic                        o_data_lines_oe,
  input wire logic                        o_vpp_high
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // write pulse: falls, three low cycles, rises
  sequence we_fall; $fell(o_write_enable_n); endsequence
  sequence we_low3; !o_write_enable_n [*3] ##1 o_write_enable_n; endsequence
  AST_WE_WIDTH: assert property (we_fall |-> we_low3)
    else $error("write pulse width off");
  AST_WRITE_PINS: assert property (!o_write_enable_n |->
    !o_chip_enable_n && o_output_enable_n && o_data_lines_oe) else $error("write pins bad");
  AST_ADDR_HELD: assert property (we_fall |-> $stable(o_addr) [*4])
    else $error("address moved in write");
  AST_DATA_HELD: assert property ($rose(o_write_enable_n) |->
    $stable(o_data_lines) && o_data_lines_oe) else $error("data moved at rise");
  AST_NO_CONTENTION: assert property (!o_output_enable_n |-> !o_data_lines_oe)
    else $error("data driven while reading");
  AST_VPP_FOR_WRITE: assert property (we_fall |-> o_vpp_high)
    else $error("write without high voltage");
  AST_CE_ADDR: assert property (!o_chip_enable_n && !$past(o_chip_enable_n) |->
    $stable(o_addr)) else $error("address moved while selected");
  AST_OE_READ: assert property ($fell(o_output_enable_n) |->
    !o_chip_enable_n && o_write_enable_n) else $error("read pins bad");
endmodule // flash_erase_host_props
bind flash_erase_host flash_erase_host_props #(.ERASE_PULSE_CYC(ERASE_PULSE_CYC),
  .LAST_ADDR(LAST_ADDR)) props (.i_clock, .i_reset_n, .o_chip_enable_n, .o_output_enable_n,
  .o_write_enable_n, .o_addr, .o_data_lines, .o_data_lines_oe, .o_vpp_high);

// *** tb/flash_part_model.sv ***
// behavioural flash part answering the host pin cycles
module flash_part_model #(
  parameter logic [7:0] MAKER = 8'h3c, // arbitrary
  parameter logic [7:0] PART  = 8'h5e, // arbitrary
  parameter int         NEED  = 2      // erase pulses before cells read erased
) (
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_vpp,
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_din,
  output logic [7:0]       o_dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [8] = '{default: 8'hff};
  logic [7:0]  cmd_q = 8'h00, val;
  logic [16:0] loc_q, pa_q;
  int          pulses = 0;
  logic        erasing = 1'b0;
  always @(negedge i_we_n) if (!i_ce_n && i_oe_n) loc_q = i_addr;
  always @(negedge i_vpp) cmd_q = 8'h00;
  always @(posedge i_we_n) if (!i_ce_n && i_oe_n && i_vpp) begin
    if (erasing && i_din == 8'ha0) begin
      pulses++;
      if (pulses >= NEED) foreach (mem[i]) mem[i] = 8'hff;
    end
    erasing = cmd_q == 8'h20 && i_din == 8'h20 && !erasing;
    if (cmd_q == 8'h40) begin
      mem[loc_q[2:0]] &= i_din;
      pa_q = loc_q;
      cmd_q = 8'h41;
    end else cmd_q = (cmd_q == 8'hff && i_din == 8'hff) ? 8'h00 : i_din;
  end
  // released lines show the inverse, so stale values never pass
  always @* begin
    case (cmd_q)
      8'h80, 8'h90: val = i_addr[0] ? PART : MAKER;
      8'ha0: val = mem[loc_q[2:0]];
      8'hc0: val = mem[pa_q[2:0]];
      default: val = mem[i_addr[2:0]];
    endcase
    o_dout = (!i_ce_n && !i_oe_n) ? val : ~val;
  end
endmodule // flash_part_model

// *** tb/flash_erase_host_tb_top.sv ***
// self-checking bench for the flash erase host
`include "flash_host_defines.svh"
module flash_erase_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_host_pkg::*;
  localparam byte_t MK = 8'h3c; // arbitrary
  localparam byte_t PT = 8'h5e; // arbitrary
  logic        i_clock = 0, i_reset_n = 0, wr_s = 0, rd_s = 0, ce_n, oe_n, we_n, doe, vpp;
  reg_addr_t   ra = '0;
  logic [31:0] wd = '0, rdata, v;
  flash_addr_t fa;
  byte_t       d_in, d_out;
  int          mismatches = 0, checked = 0;
  flash_erase_host #(.ERASE_PULSE_CYC(50), .LAST_ADDR(17'h00007)) dut (.i_clock, .i_reset_n,
    .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_write(wr_s), .i_reg_read(rd_s),
    .o_reg_rdata(rdata), .o_chip_enable_n(ce_n), .o_output_enable_n(oe_n),
    .o_write_enable_n(we_n), .o_addr(fa), .i_data_lines(d_in), .o_data_lines(d_out),
    .o_data_lines_oe(doe), .o_vpp_high(vpp));
  flash_part_model #(.MAKER(MK), .PART(PT), .NEED(2)) part (.i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_vpp(vpp), .i_addr(fa), .i_din(d_out), .o_dout(d_in));
  initial forever #12.5 i_clock = ~i_clock;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(reg_addr_t a, logic [31:0] d);
    @(posedge i_clock);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge i_clock);
    wr_s <= 1'b0;
  endtask
  task automatic rd(reg_addr_t a, output logic [31:0] r);
    @(posedge i_clock);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge i_clock);
    rd_s <= 1'b0;
    @(negedge i_clock);
    r = rdata;
  endtask
  // order, then poll status until done
  task automatic run(logic [31:0] op, logic [31:0] fl);
    wr(`REG_CMD, op);
    v = '0;
    for (int i = 0; i < 20000 && v[1] !== 1'b1; i++) rd(`REG_STAT, v);
    chk("fail", v[2:1], {fl[0], 1'b1});
  endtask
  task automatic t_novpp();
    run(2, 1);
    chk("vpp", vpp, 1'b0);
    $display("no voltage test ended");
  endtask
  task automatic t_ident();
    wr(`REG_CTRL, 1);
    run(4, 0);
    chk("id", v[23:8], {PT, MK});
    $display("id test ended");
  endtask
  task automatic t_prog();
    wr(`REG_ADDR, 3);
    wr(`REG_DATA, 32'h5a);
    run(2, 0);
    chk("cell", part.mem[3], 8'h5a);
    run(1, 0);
    rd(`REG_DATA, v);
    chk("read", v[7:0], 8'h5a);
    $display("program test ended");
  endtask
  task automatic t_erase();
    run(3, 0);
    rd(`REG_PULSE, v);
    chk("pulses", v[9:0], 10'h002);
    chk("cells", {part.mem[0], part.mem[7]}, 16'hffff);
    wr(`REG_CMD, 3);
    run(6, 1);
    run(5, 0);
    chk("latch", part.cmd_q, 8'h00);
    $display("erase test ended");
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(8'hfc, v);
    chk("unmapped", v, 0);
    t_novpp();
    t_ident();
    t_prog();
    t_erase();
    print_verdict();
  end
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
endmodule // flash_erase_host_tb_top
